// File: design/ssm_top.sv
// power-mode control, missing-clock stop exit and supply monitor with apb registers
// assumes apb master on CLK; EXT_RST_N and SUPPLY_ABOVE arrive asynchronously
// RST_N is the power-on reset; internal resets come from the sequencer
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Contract
// - stop write enters stop right after completion
// - stop halts internal oscillator, processor, peripherals
// - only a reset ends stop mode
// - after reset start fetching at address zero
// - enabled missing-clock detector resets out of stop
// - monitor enable survives all but power-on
// - early selection may cause a system reset
// - supply reset gets no reset stretch
// - monitor resets only when selected as source
// - monitor control bit 7 switches monitor
module ssm_top #(
  parameter int MCD_TIMEOUT_CYCLES = ssm_pkg::MCD_TIMEOUT_CYC,
  parameter int RESET_DELAY_CYCLES = ssm_pkg::RST_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ssm_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic WAKE_IRQ,
  input wire logic EXT_RST_N,
  input wire logic SUPPLY_ABOVE,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic INT_OSC_EN,
  output logic SUPPLY_MON_EN,
  output logic SYS_RESET_N,
  output logic CPU_START,
  output logic [15:0] FETCH_ADDR
);
  import ssm_pkg::*;

  localparam int CW = $clog2(MCD_TIMEOUT_CYCLES + 1); // stop counter width

  // register decode, shared by read and write paths
  function automatic ssm_reg_type reg_decode(input logic [APB_AW-1:0] addr);
    if (addr == PMC_ADDR) begin
      return REG_PMC;
    end else if (addr == SMC_ADDR) begin
      return REG_SMC;
    end else if (addr == RSR_ADDR) begin
      return REG_RSR;
    end else begin
      return REG_NONE;
    end
  endfunction : reg_decode

  ssm_rst_if rif(); // bundle to the reset sequencer

  // synchronisers
  logic ext_meta_reg; // external reset, first stage
  logic ext_sync_reg; // external reset, usable
  logic lvl_meta_reg; // supply comparator, first stage
  logic lvl_sync_reg; // supply comparator, usable

  // apb slave state
  logic pready_reg; // answer strobe
  logic [31:0] prdata_reg; // read data
  logic pslverr_reg; // unmapped address
  logic apb_acc; // access phase, not yet answered
  logic apb_wr; // write takes effect now
  ssm_reg_type sel_reg_kind; // decoded target
  logic [7:0] rd_byte; // read mux

  // register fields
  logic stop_reg; // in stop mode
  logic stop_next;
  logic idle_reg; // in idle mode
  logic idle_next;
  logic [PMC_GF_W-1:0] gf_reg; // general_flags
  logic mon_on_reg; // supply_monitor_on
  logic mcd_en_reg; // missing-clock detector enable
  logic supply_sel_reg; // supply_reset_select

  // missing-clock model
  logic [CW-1:0] stop_cnt_reg; // cycles spent in stop
  logic mcd_fire_reg; // detector timeout pulse

  // output flops
  logic cpu_clk_en_reg;
  logic periph_clk_en_reg;
  logic int_osc_en_reg;
  logic sys_reset_n_reg;
  logic cpu_start_reg;
  logic [15:0] fetch_addr_reg;

  // two-stage synchronisers for asynchronous pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_meta_reg <= 1'b1;
      ext_sync_reg <= 1'b1;
      lvl_meta_reg <= 1'b0;
      lvl_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= EXT_RST_N;
      ext_sync_reg <= ext_meta_reg;
      lvl_meta_reg <= SUPPLY_ABOVE;
      lvl_sync_reg <= lvl_meta_reg;
    end
  end

  // apb strobes; writes are dropped while the system is held in reset
  assign sel_reg_kind = reg_decode(PADDR);
  assign apb_acc = PSEL & PENABLE & ~pready_reg;
  assign apb_wr = PSEL & PENABLE & pready_reg & PWRITE & ~rif.in_reset;

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    if (sel_reg_kind == REG_PMC) begin
      rd_byte = {gf_reg, 2'b00}; // request bits read zero
    end else if (sel_reg_kind == REG_SMC) begin
      rd_byte[SMC_ON_BIT] = mon_on_reg;
      rd_byte[SMC_LVL_BIT] = lvl_sync_reg; // live supply state
    end else if (sel_reg_kind == REG_RSR) begin
      rd_byte[RSR_MCD_BIT] = mcd_en_reg;
      rd_byte[RSR_SEL_BIT] = supply_sel_reg;
      rd_byte[RSR_CAUSE_LSB +: 2] = rif.cause;
    end
  end

  // apb answer: one wait state, ready on the second access cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_acc;
      if (apb_acc) begin
        prdata_reg <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_reg <= (sel_reg_kind == REG_NONE);
      end else begin
        prdata_reg <= 32'h0000_0000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // next mode: stop is sticky until reset, idle ends on wake or reset
  always_comb begin
    stop_next = stop_reg;
    idle_next = idle_reg;
    if (rif.in_reset) begin
      stop_next = 1'b0; // reset is the only way out
      idle_next = 1'b0;
    end else begin
      if (apb_wr && sel_reg_kind == REG_PMC && PWDATA[PMC_STOP_BIT]) begin
        stop_next = 1'b1;
      end
      if (stop_next) begin
        idle_next = 1'b0; // wake events ignored in stop
      end else if (apb_wr && sel_reg_kind == REG_PMC && PWDATA[PMC_IDLE_BIT]) begin
        idle_next = 1'b1; // request wins over a same-cycle wake
      end else if (WAKE_IRQ) begin
        idle_next = 1'b0;
      end
    end
  end

  // mode flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_reg <= PMC_RST[PMC_STOP_BIT];
      idle_reg <= PMC_RST[PMC_IDLE_BIT];
    end else begin
      stop_reg <= stop_next;
      idle_reg <= idle_next;
    end
  end

  // general flags, cleared by any system reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gf_reg <= PMC_RST[PMC_GF_LSB +: PMC_GF_W];
    end else if (rif.in_reset) begin
      gf_reg <= PMC_RST[PMC_GF_LSB +: PMC_GF_W];
    end else if (apb_wr && sel_reg_kind == REG_PMC) begin
      gf_reg <= PWDATA[PMC_GF_LSB +: PMC_GF_W];
    end
  end

  // monitor enable: only power-on clears it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mon_on_reg <= 1'b0;
    end else if (apb_wr && sel_reg_kind == REG_SMC) begin
      mon_on_reg <= PWDATA[SMC_ON_BIT];
    end
  end

  // reset source selects, cleared by any system reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mcd_en_reg <= RSR_RST[RSR_MCD_BIT];
      supply_sel_reg <= RSR_RST[RSR_SEL_BIT];
    end else if (rif.in_reset) begin
      mcd_en_reg <= RSR_RST[RSR_MCD_BIT];
      supply_sel_reg <= RSR_RST[RSR_SEL_BIT];
    end else if (apb_wr && sel_reg_kind == REG_RSR) begin
      mcd_en_reg <= PWDATA[RSR_MCD_BIT];
      supply_sel_reg <= PWDATA[RSR_SEL_BIT];
    end
  end

  // clock is gone in stop, so an enabled detector times out
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_cnt_reg <= '0;
      mcd_fire_reg <= 1'b0;
    end else if (stop_reg && mcd_en_reg) begin
      mcd_fire_reg <= (stop_cnt_reg == CW'(MCD_TIMEOUT_CYCLES - 1));
      if (stop_cnt_reg != CW'(MCD_TIMEOUT_CYCLES - 1)) begin
        stop_cnt_reg <= stop_cnt_reg + 1'b1;
      end
    end else begin
      stop_cnt_reg <= '0;
      mcd_fire_reg <= 1'b0;
    end
  end

  // reset requests; an unselected or switched-off monitor never requests
  assign rif.req_ext = ~ext_sync_reg;
  assign rif.req_mcd = mcd_fire_reg;
  assign rif.req_supply = mon_on_reg & supply_sel_reg & ~lvl_sync_reg;

  // reset sequencer
  ssm_rst_seq #(
    .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
  ) u_seq (
    .CLK(CLK),
    .RST_N(RST_N),
    .rif(rif)
  );

  // clock gating and reset outputs; external oscillator is left alone
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cpu_clk_en_reg <= 1'b0;
      periph_clk_en_reg <= 1'b1;
      int_osc_en_reg <= 1'b1;
      sys_reset_n_reg <= 1'b0;
      cpu_start_reg <= 1'b0;
      fetch_addr_reg <= RESET_VECTOR;
    end else begin
      cpu_clk_en_reg <= ~stop_next & ~idle_next & ~rif.in_reset;
      periph_clk_en_reg <= ~stop_next;
      int_osc_en_reg <= ~stop_next;
      sys_reset_n_reg <= ~rif.in_reset;
      cpu_start_reg <= rif.done;
      fetch_addr_reg <= RESET_VECTOR;
    end
  end

  assign PREADY = pready_reg;
  assign PRDATA = prdata_reg;
  assign PSLVERR = pslverr_reg;
  assign CPU_CLK_EN = cpu_clk_en_reg;
  assign PERIPH_CLK_EN = periph_clk_en_reg;
  assign INT_OSC_EN = int_osc_en_reg;
  assign SUPPLY_MON_EN = mon_on_reg;
  assign SYS_RESET_N = sys_reset_n_reg;
  assign CPU_START = cpu_start_reg;
  assign FETCH_ADDR = fetch_addr_reg;

  // stop write enters stop and gates the processor clock at the completing edge
  property p_stop_entry;
    @(posedge CLK) disable iff (!RST_N)
      (apb_wr && sel_reg_kind == REG_PMC && PWDATA[PMC_STOP_BIT]) |=> (stop_reg && !CPU_CLK_EN);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered after write");

  property p_stop_clocks;
    @(posedge CLK) disable iff (!RST_N)
      stop_reg |-> (!INT_OSC_EN && !PERIPH_CLK_EN && !CPU_CLK_EN);
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in stop");

  property p_stop_sticky;
    @(posedge CLK) disable iff (!RST_N)
      (stop_reg && !rif.in_reset) |=> stop_reg;
  endproperty
  a_stop_sticky: assert property (p_stop_sticky) else $error("stop left without reset");

  property p_fetch_zero;
    @(posedge CLK) disable iff (!RST_N)
      rif.done |=> (CPU_START && FETCH_ADDR == RESET_VECTOR && SYS_RESET_N);
  endproperty
  a_fetch_zero: assert property (p_fetch_zero) else $error("no start at address zero");

  property p_mcd_exit;
    @(posedge CLK) disable iff (!RST_N)
      (stop_reg && mcd_en_reg && stop_cnt_reg == CW'(MCD_TIMEOUT_CYCLES - 1)) |=> ##[1:2] !SYS_RESET_N;
  endproperty
  a_mcd_exit: assert property (p_mcd_exit) else $error("detector did not reset stop");

  property p_mon_kept;
    @(posedge CLK) disable iff (!RST_N)
      rif.in_reset |=> $stable(mon_on_reg);
  endproperty
  a_mon_kept: assert property (p_mon_kept) else $error("monitor enable lost on reset");

  property p_no_unselected;
    @(posedge CLK) disable iff (!RST_N)
      (!rif.in_reset && !supply_sel_reg && ext_sync_reg && !mcd_fire_reg) |=> !rif.in_reset;
  endproperty
  a_no_unselected: assert property (p_no_unselected) else $error("reset without a selected source");

  property p_mon_switch;
    @(posedge CLK) disable iff (!RST_N)
      (apb_wr && sel_reg_kind == REG_SMC) |=> (SUPPLY_MON_EN == $past(PWDATA[SMC_ON_BIT]));
  endproperty
  a_mon_switch: assert property (p_mon_switch) else $error("monitor enable not written");

  property p_idle_gate;
    @(posedge CLK) disable iff (!RST_N)
      (idle_reg && !stop_reg) |-> (!CPU_CLK_EN && PERIPH_CLK_EN && INT_OSC_EN);
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle gated more than processor");

  property p_req_zero;
    @(posedge CLK) disable iff (!RST_N)
      (apb_acc && !PWRITE && sel_reg_kind == REG_PMC) |=> (PREADY && PRDATA[1:0] == 2'b00);
  endproperty
  a_req_zero: assert property (p_req_zero) else $error("request bits read nonzero");

  property p_level_read;
    @(posedge CLK) disable iff (!RST_N)
      (apb_acc && !PWRITE && sel_reg_kind == REG_SMC) |=> (PRDATA[SMC_LVL_BIT] == $past(lvl_sync_reg));
  endproperty
  a_level_read: assert property (p_level_read) else $error("level flag mismatch");

  c_stop_entry: cover property (@(posedge CLK) disable iff (!RST_N) $rose(stop_reg));
  c_idle_wake: cover property (@(posedge CLK) disable iff (!RST_N) $fell(idle_reg) && !rif.in_reset);
  c_mcd_fire: cover property (@(posedge CLK) disable iff (!RST_N) mcd_fire_reg);

endmodule : ssm_top

// File: design/ssm_pkg.sv
// constants, field positions and shared types of the stop/idle/supply monitor block
// assumes a 100 MHz system clock and a 32-bit apb register bus
package ssm_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 10; // system clock period
  localparam int MCD_TIMEOUT_US = 100; // missing-clock timeout
  localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_DELAY_CYC = 16; // reset stretch after non-supply causes

  // register indices; byte address is four times the index
  localparam int APB_AW = 12; // apb address width
  localparam logic [7:0] SMC_IDX = 8'hff; // supply_monitor_control
  localparam logic [7:0] PMC_IDX = 8'h80; // power_mode_control
  localparam logic [7:0] RSR_IDX = 8'h81; // reset_cause_register
  localparam logic [APB_AW-1:0] SMC_ADDR = {2'h0, SMC_IDX, 2'h0};
  localparam logic [APB_AW-1:0] PMC_ADDR = {2'h0, PMC_IDX, 2'h0};
  localparam logic [APB_AW-1:0] RSR_ADDR = {2'h0, RSR_IDX, 2'h0};

  // power_mode_control fields
  localparam int PMC_IDLE_BIT = 0; // idle request, reads zero
  localparam int PMC_STOP_BIT = 1; // stop request, reads zero
  localparam int PMC_GF_LSB = 2; // general_flags low bit
  localparam int PMC_GF_W = 6; // general_flags width
  localparam logic [7:0] PMC_RST = 8'h00;

  // supply_monitor_control fields
  localparam int SMC_ON_BIT = 7; // supply_monitor_on
  localparam int SMC_LVL_BIT = 6; // supply_level_flag, read-only

  // reset_cause_register fields
  localparam int RSR_MCD_BIT = 0; // missing-clock detector enable
  localparam int RSR_SEL_BIT = 1; // supply_reset_select
  localparam int RSR_CAUSE_LSB = 4; // last reset cause, two bits
  localparam logic [7:0] RSR_RST = 8'h00;

  // program start address after any reset
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // register decode result
  typedef enum logic [1:0] {REG_NONE, REG_PMC, REG_SMC, REG_RSR} ssm_reg_type;

  // cause of the last system reset
  typedef enum logic [1:0] {CAUSE_NONE, CAUSE_EXT, CAUSE_MCD, CAUSE_SUPPLY} ssm_cause_type;

endpackage : ssm_pkg

// File: design/ssm_rst_if.sv
// reset-request and reset-status bundle between the control logic and the reset sequencer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ssm_rst_if;
  logic req_ext; // external pin reset request, level
  logic req_mcd; // missing-clock reset request, pulse
  logic req_supply; // supply monitor reset request, level
  logic in_reset; // system reset active
  logic done; // one-cycle pulse when reset ends
  ssm_pkg::ssm_cause_type cause; // cause of the last reset

  // control side drives requests
  modport ctl (output req_ext, output req_mcd, output req_supply, input in_reset, input done, input cause);
  // sequencer side drives status
  modport seq (input req_ext, input req_mcd, input req_supply, output in_reset, output done, output cause);
endinterface : ssm_rst_if

// File: design/ssm_rst_seq.sv
// reset sequencer: holds the system in reset while a cause is present, then stretches unless the cause was supply
// assumes requests are already synchronous to CLK
`timescale 1ns/1ps
module ssm_rst_seq #(
  parameter int RESET_DELAY_CYCLES = ssm_pkg::RST_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  ssm_rst_if.seq rif
);
  import ssm_pkg::*;

  localparam int DW = $clog2(RESET_DELAY_CYCLES + 1); // delay counter width

  typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_DELAY} ssm_seq_type;

  ssm_seq_type state_reg; // sequencer state
  ssm_cause_type cause_reg; // latched cause
  logic [DW-1:0] dly_reg; // stretch counter
  logic in_reset_reg; // reset status
  logic done_reg; // end-of-reset pulse
  logic any_req; // some cause present

  assign any_req = rif.req_ext | rif.req_mcd | rif.req_supply;

  // state, cause and stretch counter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= SEQ_RUN;
      cause_reg <= CAUSE_NONE;
      dly_reg <= '0;
      in_reset_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        SEQ_RUN: begin
          // highest priority cause is recorded
          if (any_req) begin
            state_reg <= SEQ_HOLD;
            in_reset_reg <= 1'b1;
            if (rif.req_ext) cause_reg <= CAUSE_EXT;
            else if (rif.req_mcd) cause_reg <= CAUSE_MCD;
            else cause_reg <= CAUSE_SUPPLY;
          end
        end
        SEQ_HOLD: begin
          if (any_req) begin
            state_reg <= SEQ_HOLD; // cause still present
          end else if (cause_reg == CAUSE_SUPPLY) begin
            state_reg <= SEQ_RUN; // supply reset ends without stretch
            in_reset_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            state_reg <= SEQ_DELAY;
            dly_reg <= '0;
          end
        end
        SEQ_DELAY: begin
          if (any_req) begin
            state_reg <= SEQ_HOLD; // new cause restarts the hold
          end else if (dly_reg == DW'(RESET_DELAY_CYCLES - 1)) begin
            state_reg <= SEQ_RUN;
            in_reset_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            dly_reg <= dly_reg + 1'b1;
          end
        end
        default: state_reg <= SEQ_RUN;
      endcase
    end
  end

  assign rif.in_reset = in_reset_reg;
  assign rif.done = done_reg;
  assign rif.cause = cause_reg;

  // supply reset releases on the cycle after the cause goes away
  property p_supply_no_delay;
    @(posedge CLK) disable iff (!RST_N)
      (state_reg == SEQ_HOLD && cause_reg == CAUSE_SUPPLY && !any_req) |=> (!in_reset_reg && done_reg);
  endproperty
  a_supply_no_delay: assert property (p_supply_no_delay) else $error("supply reset was stretched");

  // other causes still hold reset the cycle after the cause goes away
  property p_other_delay;
    @(posedge CLK) disable iff (!RST_N)
      (state_reg == SEQ_HOLD && cause_reg != CAUSE_SUPPLY && !any_req) ##1 (!any_req)[*1] |-> in_reset_reg;
  endproperty
  a_other_delay: assert property (p_other_delay) else $error("non-supply reset ended without stretch");

  c_supply_reset: cover property (@(posedge CLK) disable iff (!RST_N) done_reg && cause_reg == CAUSE_SUPPLY);
  c_mcd_reset: cover property (@(posedge CLK) disable iff (!RST_N) done_reg && cause_reg == CAUSE_MCD);

endmodule : ssm_rst_seq

// File: bench/ssm_top_bench.sv
// self-checking bench for the stop/idle/supply monitor top with its apb registers
// assumes ssm_pkg and the design files are compiled first; one 100 MHz clock
`timescale 1ns/1ps
module ssm_top_bench;
  import ssm_pkg::*;
  localparam int MCD = 20; // shortened detector timeout
  localparam int RD = 4; // shortened reset stretch
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // power-on reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
  logic [APB_AW-1:0] paddr = '0; // apb byte address
  logic [31:0] pwdata = '0; // apb write data
  logic pready, pslverr, cpu_clk_en, periph_clk_en, int_osc_en, supply_mon_en, sys_reset_n, cpu_start;
  logic [31:0] prdata; // apb read data
  logic [15:0] fetch_addr; // start address
  logic wake_irq = 1'b0; // idle wake request
  logic ext_rst_n = 1'b1; // reset pin, active low
  logic supply_above = 1'b1; // comparator output
  int n_errors = 0; // mismatches
  int checked = 0; // comparisons
  logic [31:0] rd; // last read data
  logic err; // last slave error
  int lo; // reset low span

  // design under test with short counts
  ssm_top #(.MCD_TIMEOUT_CYCLES(MCD), .RESET_DELAY_CYCLES(RD)) dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .WAKE_IRQ(wake_irq), .EXT_RST_N(ext_rst_n), .SUPPLY_ABOVE(supply_above),
    .CPU_CLK_EN(cpu_clk_en), .PERIPH_CLK_EN(periph_clk_en), .INT_OSC_EN(int_osc_en),
    .SUPPLY_MON_EN(supply_mon_en), .SYS_RESET_N(sys_reset_n), .CPU_START(cpu_start), .FETCH_ADDR(fetch_addr));

  // free-running clock
  always #5 clk = ~clk;

  // one comparison, four-state exact
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready with a bound
  task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : apb

  // waits for a system reset to start and end, then checks the restart
  task wait_rst(output int lo_n);
    int n;
    n = 0;
    lo_n = 0;
    while (sys_reset_n !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (sys_reset_n !== 1'b1 && lo_n < 200) begin
      @(posedge clk);
      #1;
      lo_n++;
    end
    chk(cpu_start, 1'b1);
    chk(fetch_addr, RESET_VECTOR);
    chk(cpu_clk_en & int_osc_en & periph_clk_en, 1'b1);
    if (n >= 200 || lo_n >= 200) chk(32'h0, 32'h1);
    @(posedge clk);
  endtask : wait_rst

  // power-on values of registers and outputs
  task t_reset;
    apb(1'b0, PMC_ADDR, 32'h0);
    chk(rd, {24'h0, PMC_RST});
    apb(1'b0, SMC_ADDR, 32'h0);
    chk(rd, 32'h40);
    chk({cpu_clk_en, periph_clk_en, int_osc_en, supply_mon_en}, 4'he);
  endtask : t_reset

  // flags read-write, request bits read zero, idle gates the processor only
  task t_idle;
    apb(1'b1, PMC_ADDR, 32'hfd);
    #1;
    chk({cpu_clk_en, periph_clk_en, int_osc_en}, 3'h3);
    apb(1'b0, PMC_ADDR, 32'h0);
    chk(rd, 32'hfc);
    chk(cpu_clk_en, 1'b0);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    #1;
    chk(cpu_clk_en, 1'b1);
  endtask : t_idle

  // unmapped address is refused
  task t_unmapped;
    apb(1'b1, 12'h100, 32'hff);
    chk(err, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask : t_unmapped

  // monitor switch, status flag, select ordering and no reset stretch
  task t_supply;
    apb(1'b1, SMC_ADDR, 32'h80);
    supply_above <= 1'b0;
    #1;
    chk(supply_mon_en, 1'b1);
    repeat (6) @(posedge clk);
    apb(1'b0, SMC_ADDR, 32'h0);
    chk(rd, 32'h80);
    chk(sys_reset_n, 1'b1);
    apb(1'b1, RSR_ADDR, 32'h02);
    wait_rst(lo);
    chk(lo < RD, 1'b1);
    chk(supply_mon_en, 1'b1);
    supply_above <= 1'b1;
    apb(1'b0, RSR_ADDR, 32'h0);
    chk(rd, 32'h30);
    // settled monitor selected after a wait, then again with no wait
    repeat (4) @(posedge clk);
    apb(1'b1, RSR_ADDR, 32'h02);
    apb(1'b1, SMC_ADDR, 32'h80);
    apb(1'b1, RSR_ADDR, 32'h02);
    apb(1'b0, RSR_ADDR, 32'h0);
    chk(rd, 32'h32);
    chk(sys_reset_n, 1'b1);
  endtask : t_supply

  // stop without detector: no wake but reset; pin reset is stretched
  task t_stop_ext;
    apb(1'b1, RSR_ADDR, 32'h00);
    apb(1'b1, PMC_ADDR, 32'h02);
    wake_irq <= 1'b1;
    #1;
    chk({cpu_clk_en, periph_clk_en, int_osc_en}, 3'h0);
    repeat (3 * MCD) @(posedge clk);
    wake_irq <= 1'b0;
    ext_rst_n <= 1'b0;
    #1;
    chk({int_osc_en, sys_reset_n, supply_mon_en}, 3'h3);
    repeat (4) @(posedge clk);
    ext_rst_n <= 1'b1;
    wait_rst(lo);
    chk(lo >= RD, 1'b1);
    chk(supply_mon_en, 1'b1);
  endtask : t_stop_ext

  // stop with detector enabled ends by internal reset after the timeout
  task t_stop_mcd;
    int n;
    n = 0;
    apb(1'b1, SMC_ADDR, 32'h00);
    apb(1'b1, RSR_ADDR, 32'h01);
    apb(1'b1, PMC_ADDR, 32'h02);
    while (sys_reset_n !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= MCD && n <= MCD + 8, 1'b1);
    wait_rst(lo);
    chk(supply_mon_en, 1'b0);
    apb(1'b0, RSR_ADDR, 32'h0);
    chk(rd, 32'h20);
  endtask : t_stop_mcd

  // counts, verdict and end of run
  task summarize;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_idle();
    t_unmapped();
    t_supply();
    t_stop_ext();
    t_stop_mcd();
    summarize();
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : ssm_top_bench
